// ===== design/pms_regs.svh
// register map, field positions and reset values of the power supervision block
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PMS_ADDR_CTRL_ONE   12'h000
`define PMS_ADDR_CTRL_TWO   12'h004
`define PMS_ADDR_IRQ_STAT   12'h008
`define PMS_ADDR_IRQ_CLR    12'h00c
`define PMS_ADDR_IRQ_EN     12'h010
`define PMS_ADDR_W          12

// ----------------------------------------------------------------
// control one fields
// ----------------------------------------------------------------
`define PMS_C1_DET_FLAG     7
`define PMS_C1_DET_ACK      6
`define PMS_C1_IRQ_EN       5
`define PMS_C1_RST_EN       4
`define PMS_C1_STOP_EN      3
`define PMS_C1_LOGIC_EN     2
`define PMS_C1_BG_EN        0

// ----------------------------------------------------------------
// control two fields
// ----------------------------------------------------------------
`define PMS_C2_WARN_FLAG    7
`define PMS_C2_WARN_ACK     6
`define PMS_C2_DET_TRIP     5
`define PMS_C2_WARN_TRIP    4
`define PMS_C2_S2_FLAG      3
`define PMS_C2_S2_ACK       2
`define PMS_C2_DEPTH        0

// ----------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------
`define PMS_EV_DETECT       0
`define PMS_EV_WARN         1
`define PMS_EV_S2           2
`define PMS_EV_N            3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMS_RST_CTRL        1'b0
`define PMS_RST_ZERO8       8'h00
`define PMS_RST_EV          3'h0

`endif

// ===== design/pms_pkg.sv
// types shared by the power supervision block
package pms_pkg;

    // analog comparator and mode status toward the block
    typedef struct packed {
        logic undervolt_event;
        logic warning_present;
        logic stop_active;
        logic stop2_wake;
    } pms_sense_t;

    // control levels toward the analog and reset logic
    typedef struct packed {
        logic undervolt_logic_enable;
        logic undervolt_active;
        logic undervolt_trip_select;
        logic warning_trip_select;
        logic bandgap_buffer_enable;
        logic stop_depth_select;
    } pms_ctrl_t;

    // decoded register access
    typedef enum {
        PMS_SEL_NONE,
        PMS_SEL_ONE,
        PMS_SEL_TWO,
        PMS_SEL_STAT,
        PMS_SEL_CLR,
        PMS_SEL_EN
    } pms_sel_t;

endpackage

// ===== design/pms_sync.sv
// two flip-flop synchroniser for the sense levels
module pms_sync #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] dout_q;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            dout_q <= '0;
        end else begin
            meta_q <= din;
            dout_q <= meta_q;
        end
    end

    assign dout = dout_q;

endmodule

// ===== design/pms_ctrl.sv
// power supervision status and control registers with apb slave
//
// How it works
// - detect flag bit 7 sets on undervolt event while detection is enabled
// - writing 1 to detect ack bit 6 clears detect flag; reads zero
// - interrupt enable bit 5 requests interrupt while detect flag set
// - reset enable bit 4 with detection enabled forces reset while flag set
// - stop enable bit 3 keeps detection running during stop mode
// - logic enable bit 2 turns detection on and qualifies bits 5, 4 and 3
// - bit 0 of control one drives the bandgap buffer enable
// - warning flag sets on warning and stays until acknowledged
// - warning ack clears the flag only when no warning is present
// - warning flag sets on crossing and after reset if still low
// - detect trip select accepts one write after power-on, kept on resets
// - warning trip select cleared by power-on only
// - stop2 recovery flag bit 3 reads 1 after leaving stop2
// - writing 1 to stop2 ack bit 2 clears recovery flag; reads zero
// - stop depth bit 0 accepts one write after reset
`include "pms_regs.svh"

module pms_ctrl (
    // clock and resets
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              por_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // analog and mode status, asynchronous
    input  pms_pkg::pms_sense_t    sense,
    // control outputs
    output pms_pkg::pms_ctrl_t     ctrl,
    output logic                   undervolt_irq,
    output logic                   undervolt_reset_req,
    output logic                   irq
);
    import pms_pkg::*;

    // ----------------------------------------------------------------
    // sense synchronisation
    // ----------------------------------------------------------------
    logic [3:0] sense_s;
    logic       s_event;
    logic       s_warn;
    logic       s_stop;
    logic       s_wake;

    pms_sync #(.W(4)) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .din     (sense),
        .dout    (sense_s)
    );

    assign s_event = sense_s[3];
    assign s_warn  = sense_s[2];
    assign s_stop  = sense_s[1];
    assign s_wake  = sense_s[0];

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    function automatic pms_sel_t decode(input logic [11:0] a);
        case (a)
            `PMS_ADDR_CTRL_ONE: decode = PMS_SEL_ONE;
            `PMS_ADDR_CTRL_TWO: decode = PMS_SEL_TWO;
            `PMS_ADDR_IRQ_STAT: decode = PMS_SEL_STAT;
            `PMS_ADDR_IRQ_CLR:  decode = PMS_SEL_CLR;
            `PMS_ADDR_IRQ_EN:   decode = PMS_SEL_EN;
            default:            decode = PMS_SEL_NONE;
        endcase
    endfunction

    pms_sel_t sel;
    logic     acc;
    logic     wr;
    logic     wr_one;
    logic     wr_two;

    assign sel     = decode(paddr);
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign wr_one  = wr & (sel == PMS_SEL_ONE);
    assign wr_two  = wr & (sel == PMS_SEL_TWO);
    assign pready  = 1'b1;                           // zero wait states
    assign pslverr = acc & (sel == PMS_SEL_NONE);    // unmapped address

    // ----------------------------------------------------------------
    // control one state
    // ----------------------------------------------------------------
    logic det_flag_q,  det_flag_d;
    logic irq_en_q,    irq_en_d;
    logic rst_en_q,    rst_en_d;
    logic stop_en_q,   stop_en_d;
    logic logic_en_q,  logic_en_d;
    logic bg_en_q,     bg_en_d;
    logic det_active;

    // detection runs when enabled, and in stop only with stop enable
    assign det_active = logic_en_q & (~s_stop | stop_en_q);

    always_comb begin
        irq_en_d   = irq_en_q;
        rst_en_d   = rst_en_q;
        stop_en_d  = stop_en_q;
        logic_en_d = logic_en_q;
        bg_en_d    = bg_en_q;
        det_flag_d = det_flag_q;
        if (wr_one) begin
            irq_en_d   = pwdata[`PMS_C1_IRQ_EN];
            rst_en_d   = pwdata[`PMS_C1_RST_EN];
            stop_en_d  = pwdata[`PMS_C1_STOP_EN];
            logic_en_d = pwdata[`PMS_C1_LOGIC_EN];
            bg_en_d    = pwdata[`PMS_C1_BG_EN];
            if (pwdata[`PMS_C1_DET_ACK]) begin
                det_flag_d = 1'b0;
            end
        end
        // set wins over acknowledge
        if (det_active && s_event) begin
            det_flag_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            det_flag_q <= `PMS_RST_CTRL;
            irq_en_q   <= `PMS_RST_CTRL;
            rst_en_q   <= `PMS_RST_CTRL;
            stop_en_q  <= `PMS_RST_CTRL;
            logic_en_q <= `PMS_RST_CTRL;
            bg_en_q    <= `PMS_RST_CTRL;
        end else begin
            det_flag_q <= det_flag_d;
            irq_en_q   <= irq_en_d;
            rst_en_q   <= rst_en_d;
            stop_en_q  <= stop_en_d;
            logic_en_q <= logic_en_d;
            bg_en_q    <= bg_en_d;
        end
    end

    // ----------------------------------------------------------------
    // control two: power-on domain (trip selects)
    // ----------------------------------------------------------------
    logic det_trip_q, det_trip_d;
    logic wtrip_q,    wtrip_d;
    logic det_lock_q, det_lock_d;

    always_comb begin
        det_trip_d = det_trip_q;
        wtrip_d    = wtrip_q;
        det_lock_d = det_lock_q;
        if (wr_two) begin
            wtrip_d = pwdata[`PMS_C2_WARN_TRIP];
            if (!det_lock_q) begin
                det_trip_d = pwdata[`PMS_C2_DET_TRIP];
                det_lock_d = 1'b1;
            end
        end
    end

    // only power-on clears these
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            det_trip_q <= `PMS_RST_CTRL;
            wtrip_q    <= `PMS_RST_CTRL;
            det_lock_q <= `PMS_RST_CTRL;
        end else begin
            det_trip_q <= det_trip_d;
            wtrip_q    <= wtrip_d;
            det_lock_q <= det_lock_d;
        end
    end

    // ----------------------------------------------------------------
    // control two: ordinary reset domain
    // ----------------------------------------------------------------
    logic warn_flag_q,  warn_flag_d;
    logic s2_flag_q,    s2_flag_d;
    logic depth_q,      depth_d;
    logic depth_lock_q, depth_lock_d;
    logic wake_prev_q;

    always_comb begin
        warn_flag_d  = warn_flag_q;
        s2_flag_d    = s2_flag_q;
        depth_d      = depth_q;
        depth_lock_d = depth_lock_q;
        if (wr_two) begin
            if (pwdata[`PMS_C2_WARN_ACK] && !s_warn) begin
                warn_flag_d = 1'b0;
            end
            if (pwdata[`PMS_C2_S2_ACK]) begin
                s2_flag_d = 1'b0;
            end
            if (!depth_lock_q) begin
                depth_d      = pwdata[`PMS_C2_DEPTH];
                depth_lock_d = 1'b1;
            end
        end
        // present warning, also straight after reset, sets the flag
        if (s_warn) begin
            warn_flag_d = 1'b1;
        end
        // rising edge of stop2 wake marks recovery, beats acknowledge
        if (s_wake && !wake_prev_q) begin
            s2_flag_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            warn_flag_q  <= `PMS_RST_CTRL;
            s2_flag_q    <= `PMS_RST_CTRL;
            depth_q      <= `PMS_RST_CTRL;
            depth_lock_q <= `PMS_RST_CTRL;
            wake_prev_q  <= `PMS_RST_CTRL;
        end else begin
            warn_flag_q  <= warn_flag_d;
            s2_flag_q    <= s2_flag_d;
            depth_q      <= depth_d;
            depth_lock_q <= depth_lock_d;
            wake_prev_q  <= s_wake;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, clear and enable
    // ----------------------------------------------------------------
    logic [`PMS_EV_N-1:0] ev_stat_q, ev_stat_d;
    logic [`PMS_EV_N-1:0] ev_en_q,   ev_en_d;
    logic [`PMS_EV_N-1:0] ev_set;

    assign ev_set[`PMS_EV_DETECT] = det_active & s_event & ~det_flag_q;
    assign ev_set[`PMS_EV_WARN]   = s_warn & ~warn_flag_q;
    assign ev_set[`PMS_EV_S2]     = s_wake & ~wake_prev_q;

    always_comb begin
        ev_stat_d = ev_stat_q;
        ev_en_d   = ev_en_q;
        if (wr && sel == PMS_SEL_CLR) begin
            ev_stat_d = ev_stat_q & ~pwdata[`PMS_EV_N-1:0];
        end
        if (wr && sel == PMS_SEL_EN) begin
            ev_en_d = pwdata[`PMS_EV_N-1:0];
        end
        ev_stat_d = ev_stat_d | ev_set;        // set wins over clear
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ev_stat_q <= `PMS_RST_EV;
            ev_en_q   <= `PMS_RST_EV;
        end else begin
            ev_stat_q <= ev_stat_d;
            ev_en_q   <= ev_en_d;
        end
    end

    assign irq = |(ev_stat_q & ev_en_q);

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign undervolt_irq       = det_flag_q & irq_en_q & logic_en_q;
    assign undervolt_reset_req = det_flag_q & rst_en_q & logic_en_q;

    always_comb begin
        ctrl.undervolt_logic_enable = logic_en_q;
        ctrl.undervolt_active       = det_active;
        ctrl.undervolt_trip_select  = det_trip_q;
        ctrl.warning_trip_select    = wtrip_q;
        ctrl.bandgap_buffer_enable  = bg_en_q;
        ctrl.stop_depth_select      = depth_q;
    end

    // ----------------------------------------------------------------
    // read data, ack bits read as zero
    // ----------------------------------------------------------------
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        case (sel)
            PMS_SEL_ONE: begin
                rdata[`PMS_C1_DET_FLAG] = det_flag_q;
                rdata[`PMS_C1_IRQ_EN]   = irq_en_q;
                rdata[`PMS_C1_RST_EN]   = rst_en_q;
                rdata[`PMS_C1_STOP_EN]  = stop_en_q;
                rdata[`PMS_C1_LOGIC_EN] = logic_en_q;
                rdata[`PMS_C1_BG_EN]    = bg_en_q;
            end
            PMS_SEL_TWO: begin
                rdata[`PMS_C2_WARN_FLAG] = warn_flag_q;
                rdata[`PMS_C2_DET_TRIP]  = det_trip_q;
                rdata[`PMS_C2_WARN_TRIP] = wtrip_q;
                rdata[`PMS_C2_S2_FLAG]   = s2_flag_q;
                rdata[`PMS_C2_DEPTH]     = depth_q;
            end
            PMS_SEL_STAT: rdata[`PMS_EV_N-1:0] = ev_stat_q;
            PMS_SEL_EN:   rdata[`PMS_EV_N-1:0] = ev_en_q;
            default:      rdata = 32'h0000_0000;
        endcase
    end

    assign prdata = rdata;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_det_flag_set: assert property (@(posedge sys_clk) disable iff (!resetn)
        det_active && s_event |=> det_flag_q) else $error("detect flag not set");
    a_det_ack_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_one && pwdata[`PMS_C1_DET_ACK] && !(det_active && s_event) |=> !det_flag_q)
        else $error("detect ack failed");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!resetn)
        undervolt_irq == (det_flag_q && irq_en_q && logic_en_q)) else $error("irq wrong");
    a_reset_req: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(undervolt_reset_req) |-> rst_en_q && logic_en_q) else $error("reset req wrong");
    a_stop_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_stop && !stop_en_q |-> !ctrl.undervolt_active) else $error("stop gate wrong");
    a_warn_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        warn_flag_q && !wr_two |=> warn_flag_q) else $error("warning flag dropped");
    a_warn_ack_block: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_warn |=> warn_flag_q) else $error("warning cleared while present");
    a_trip_once: assert property (@(posedge sys_clk) disable iff (!por_n)
        det_lock_q |=> $stable(det_trip_q)) else $error("trip select rewritten");
    a_depth_once: assert property (@(posedge sys_clk) disable iff (!resetn)
        depth_lock_q |=> $stable(depth_q)) else $error("stop depth rewritten");
    a_s2_ack_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_two && pwdata[`PMS_C2_S2_ACK] && !(s_wake && !wake_prev_q) |=> !s2_flag_q)
        else $error("stop2 ack failed");
    a_s2_set: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_wake && !wake_prev_q |=> s2_flag_q) else $error("stop2 flag not set");

    c_det_irq:  cover property (@(posedge sys_clk) disable iff (!resetn) $rose(undervolt_irq));
    c_det_rst:  cover property (@(posedge sys_clk) disable iff (!resetn) $rose(undervolt_reset_req));
    c_warn_ack: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(warn_flag_q));
    c_s2_ack:   cover property (@(posedge sys_clk) disable iff (!resetn) $fell(s2_flag_q));

endmodule

// ===== sim/pms_ctrl_bench.sv
// self-checking bench for the power supervision status and control block
`include "pms_regs.svh"

module pms_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pms_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        sys_clk;
    logic        resetn;
    logic        por_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    pms_sense_t  sense;
    pms_ctrl_t   ctrl;
    logic        undervolt_irq;
    logic        undervolt_reset_req;
    logic        irq;
    logic        chk_req;
    logic [32:0] exp_q[$];
    int          mismatches;
    int          total_checks;
    logic [7:0]  lfsr;
    logic [7:0]  v;

    pms_ctrl pms_ctrl_inst (
        .sys_clk(sys_clk), .resetn(resetn), .por_n(por_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense), .ctrl(ctrl),
        .undervolt_irq(undervolt_irq), .undervolt_reset_req(undervolt_reset_req), .irq(irq)
    );

    // 40 MHz clock
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // expected {ctrl, undervolt_irq, undervolt_reset_req, irq}
    function automatic logic [8:0] exp_out(input logic [7:0] c1, input logic [7:0] c2,
                                           input logic stp, input logic irqv);
        return {c1[2], c1[2] & (~stp | c1[3]), c2[5], c2[4], c1[0], c2[0],
                c1[7] & c1[5] & c1[2], c1[7] & c1[4] & c1[2], irqv};
    endfunction

    task automatic summarize();
        if (exp_q.size() != 0)
            mismatches++;
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic wr(input logic [11:0] addr, input logic [7:0] data);
        apb(1'b1, addr, {24'h0, data});
    endtask

    task automatic rd(input logic [11:0] addr, input logic [7:0] exp, input logic err);
        exp_q.push_back({err, 24'h0, exp});
        apb(1'b0, addr, 32'h0);
    endtask

    task automatic chk_out(input logic [8:0] exp);
        exp_q.push_back({24'h0, exp});
        @(posedge sys_clk);
        chk_req <= 1'b1;
        @(posedge sys_clk);
        chk_req <= 1'b0;
    endtask

    // monitor: oldest note against each read result or output sample
    always @(posedge sys_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() == 0)
                mismatches++;
            else
                check({pslverr, prdata}, exp_q.pop_front());
        end else if (chk_req === 1'b1) begin
            if (exp_q.size() == 0)
                mismatches++;
            else
                check({24'h0, ctrl, undervolt_irq, undervolt_reset_req, irq}, exp_q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, chk_req, resetn, por_n} = '0;
        paddr = '0;
        pwdata = '0;
        sense = '0;
        mismatches = 0;
        total_checks = 0;
        lfsr = 8'h3c;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        por_n  <= 1'b1;
        // reset values and unmapped access
        rd(`PMS_ADDR_CTRL_ONE, 8'h00, 1'b0);
        rd(`PMS_ADDR_CTRL_TWO, 8'h00, 1'b0);
        rd(`PMS_ADDR_IRQ_STAT, 8'h00, 1'b0);
        rd(`PMS_ADDR_IRQ_EN, 8'h00, 1'b0);
        chk_out(9'h000);
        rd(12'h014, 8'h00, 1'b1);
        // random control one values, reserved bit kept zero
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            v = lfsr & 8'h3d;
            wr(`PMS_ADDR_CTRL_ONE, v);
            rd(`PMS_ADDR_CTRL_ONE, v, 1'b0);
            chk_out(exp_out(v, 8'h00, 1'b0, 1'b0));
        end
        // detect event, interrupt raise, mask, acknowledge, clear
        wr(`PMS_ADDR_CTRL_ONE, 8'h3d);
        sense.undervolt_event <= 1'b1;
        idle(5);
        rd(`PMS_ADDR_CTRL_ONE, 8'hbd, 1'b0);
        chk_out(exp_out(8'hbd, 8'h00, 1'b0, 1'b0));
        rd(`PMS_ADDR_IRQ_STAT, 8'h01, 1'b0);
        wr(`PMS_ADDR_IRQ_EN, 8'h01);
        rd(`PMS_ADDR_IRQ_EN, 8'h01, 1'b0);
        chk_out(exp_out(8'hbd, 8'h00, 1'b0, 1'b1));
        wr(`PMS_ADDR_IRQ_EN, 8'h00);
        chk_out(exp_out(8'hbd, 8'h00, 1'b0, 1'b0));
        sense.undervolt_event <= 1'b0;
        idle(5);
        wr(`PMS_ADDR_CTRL_ONE, 8'h3d);
        rd(`PMS_ADDR_CTRL_ONE, 8'hbd, 1'b0);
        wr(`PMS_ADDR_CTRL_ONE, 8'h7d);
        rd(`PMS_ADDR_CTRL_ONE, 8'h3d, 1'b0);
        chk_out(exp_out(8'h3d, 8'h00, 1'b0, 1'b0));
        wr(`PMS_ADDR_IRQ_CLR, 8'h01);
        rd(`PMS_ADDR_IRQ_STAT, 8'h00, 1'b0);
        // detection disabled ignores events
        wr(`PMS_ADDR_CTRL_ONE, 8'h31);
        sense.undervolt_event <= 1'b1;
        idle(5);
        rd(`PMS_ADDR_CTRL_ONE, 8'h31, 1'b0);
        chk_out(exp_out(8'h31, 8'h00, 1'b0, 1'b0));
        // stop mode with and without stop enable; stop is seen before detection turns on
        sense.stop_active <= 1'b1;
        idle(5);
        wr(`PMS_ADDR_CTRL_ONE, 8'h04);
        idle(5);
        rd(`PMS_ADDR_CTRL_ONE, 8'h04, 1'b0);
        chk_out(exp_out(8'h04, 8'h00, 1'b1, 1'b0));
        wr(`PMS_ADDR_CTRL_ONE, 8'h0c);
        idle(5);
        rd(`PMS_ADDR_CTRL_ONE, 8'h8c, 1'b0);
        {sense.stop_active, sense.undervolt_event} <= 2'b00;
        idle(5);
        wr(`PMS_ADDR_CTRL_ONE, 8'h4c);
        rd(`PMS_ADDR_CTRL_ONE, 8'h0c, 1'b0);
        // once-only bits of control two
        wr(`PMS_ADDR_CTRL_TWO, 8'h31);
        rd(`PMS_ADDR_CTRL_TWO, 8'h31, 1'b0);
        chk_out(exp_out(8'h0c, 8'h31, 1'b0, 1'b0));
        wr(`PMS_ADDR_CTRL_TWO, 8'h00);
        rd(`PMS_ADDR_CTRL_TWO, 8'h21, 1'b0);
        // warning flag is sticky and acknowledged only when gone
        sense.warning_present <= 1'b1;
        idle(5);
        rd(`PMS_ADDR_CTRL_TWO, 8'ha1, 1'b0);
        wr(`PMS_ADDR_CTRL_TWO, 8'h40);
        rd(`PMS_ADDR_CTRL_TWO, 8'ha1, 1'b0);
        sense.warning_present <= 1'b0;
        idle(5);
        rd(`PMS_ADDR_CTRL_TWO, 8'ha1, 1'b0);
        wr(`PMS_ADDR_CTRL_TWO, 8'h40);
        rd(`PMS_ADDR_CTRL_TWO, 8'h21, 1'b0);
        // stop2 recovery, checked then acknowledged by software
        sense.stop2_wake <= 1'b1;
        idle(5);
        rd(`PMS_ADDR_CTRL_TWO, 8'h29, 1'b0);
        sense.stop2_wake <= 1'b0;
        wr(`PMS_ADDR_CTRL_TWO, 8'h04);
        rd(`PMS_ADDR_CTRL_TWO, 8'h21, 1'b0);
        // collected events on the interrupt output
        rd(`PMS_ADDR_IRQ_STAT, 8'h07, 1'b0);
        wr(`PMS_ADDR_IRQ_EN, 8'h07);
        chk_out(exp_out(8'h0c, 8'h21, 1'b0, 1'b1));
        wr(`PMS_ADDR_IRQ_CLR, 8'h07);
        rd(`PMS_ADDR_IRQ_STAT, 8'h00, 1'b0);
        chk_out(exp_out(8'h0c, 8'h21, 1'b0, 1'b0));
        // ordinary reset keeps trip selects and rearms the depth lock
        wr(`PMS_ADDR_CTRL_TWO, 8'h10);
        sense.warning_present <= 1'b1;
        resetn <= 1'b0;
        idle(3);
        resetn <= 1'b1;
        idle(5);
        rd(`PMS_ADDR_CTRL_TWO, 8'hb0, 1'b0);
        rd(`PMS_ADDR_CTRL_ONE, 8'h00, 1'b0);
        wr(`PMS_ADDR_CTRL_TWO, 8'h11);
        rd(`PMS_ADDR_CTRL_TWO, 8'hb1, 1'b0);
        wr(`PMS_ADDR_CTRL_TWO, 8'h00);
        rd(`PMS_ADDR_CTRL_TWO, 8'ha1, 1'b0);
        // power-on reset clears the trip selects
        sense.warning_present <= 1'b0;
        {resetn, por_n} <= 2'b00;
        idle(3);
        {resetn, por_n} <= 2'b11;
        idle(5);
        rd(`PMS_ADDR_CTRL_TWO, 8'h00, 1'b0);
        idle(2);
        summarize();
    end
endmodule
